// [aoid_pkg.sv]
// Purpose: constants for the output ID encoder of the translation unit ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   widths are defaults; the encoder derives the port widths from them
// Overview of operation
// - each plain buffer port drives an ID one bit wider than its input ID.
// - extra top ID bit marks barrier transactions the buffer generates itself.
// - control unit's own port ID width is walk tag width plus one.
// - walk tag width is log2 of walk queue count rounded up to power of two.
// - control unit's extra top ID bit is set for both sync-complete and table-walk reads.
// - shared port with buffer ID width up to tag width uses tag width plus two.
// - shared port with buffer ID width above tag width uses buffer width plus one.
// - forwarded transaction keeps its ID in low bits, upper bits zero.
// - buffer-generated synchronisation transaction drives all ID bits to one.
// - table-walk read ID has 0b10 on top, zeros down to tag width; on the control unit's own port only the top 1 sits above the tag.
// - table-walk read carries the walk tag in the low tag-width bits.
// - sync-complete ID has 0b110 on top (0b11 on a two-bit port), all lower bits zero.
// - each buffer port keeps up to 256 transactions outstanding; ready drops at 256 and between requests.
package aoid_pkg;
	localparam int AOID_IN_ID_W      = 8;
	localparam int AOID_WALK_QUEUES  = 8;
	localparam int AOID_MAX_OUTSTAND = 256;
	localparam logic [1:0] AOID_WALK_TOP = 2'h2;
	localparam logic [2:0] AOID_SYNC_TOP = 3'h6;

	typedef enum logic [1:0] {
		AOID_SRC_FWD,
		AOID_SRC_BARRIER,
		AOID_SRC_WALK,
		AOID_SRC_SYNC_DONE
	} aoid_src_t;

	function automatic int aoid_tag_w(input int queues);
		int w;
		w = 0;
		while ((1 << w) < queues) begin
			w = w + 1;
		end
		return (w < 1) ? 1 : w;
	endfunction : aoid_tag_w
endpackage : aoid_pkg

// [aoid_out_cnt.sv]
`timescale 1ns/1ps
// Purpose: outstanding transaction counter for one direction of a port
// Assumes: issue and retire are single-cycle handshake pulses
// Notes:   saturating; full only when max transactions are in flight
module aoid_out_cnt #(
	parameter int MAX = 256
) (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire logic                     i_issue,
	input  wire logic                     i_retire,
	output logic                          o_full,
	output logic [$clog2(MAX+1)-1:0]      o_count
);
	localparam int CW = $clog2(MAX + 1);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (i_issue && !i_retire && cnt_ff != CW'(MAX)) begin
			nxt_cnt = cnt_ff + CW'(1);
		end else if (!i_issue && i_retire && cnt_ff != '0) begin
			nxt_cnt = cnt_ff - CW'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign o_full  = (cnt_ff == CW'(MAX));
	assign o_count = cnt_ff;
endmodule : aoid_out_cnt

// [aoid_encoder.sv]
`timescale 1ns/1ps
// Purpose: output ID width selection and ID encoding for one master port
// Assumes: MUXED=1 means buffer and control unit share this port,
//          SEPARATE_CTL=1 means this port belongs to the control unit alone
// Notes:   at most one request every other cycle; ID registered with its valid
module aoid_encoder #(
	parameter int IN_ID_W     = aoid_pkg::AOID_IN_ID_W,
	parameter int WALK_QUEUES = aoid_pkg::AOID_WALK_QUEUES,
	parameter int MAX_OUT     = aoid_pkg::AOID_MAX_OUTSTAND,
	parameter bit MUXED        = 1'b0,
	parameter bit SEPARATE_CTL = 1'b0,
	localparam int TAG_W = aoid_pkg::aoid_tag_w(WALK_QUEUES),
	localparam int OUT_W = SEPARATE_CTL ? TAG_W + 1 :
		(!MUXED ? IN_ID_W + 1 :
		((IN_ID_W <= TAG_W) ? TAG_W + 2 : IN_ID_W + 1))
) (
	input  wire logic                  I_CLK_SYS,
	input  wire logic                  I_RST_N,
	input  wire logic                  I_REQ_VALID,
	input  wire aoid_pkg::aoid_src_t   I_REQ_SRC,
	input  wire logic [IN_ID_W-1:0]    I_REQ_ID,
	input  wire logic [TAG_W-1:0]      I_WALK_TAG,
	output logic                       O_REQ_READY,
	output logic                       O_ID_VALID,
	output logic [OUT_W-1:0]           O_ID,
	input  wire logic                  I_ID_READY,
	input  wire logic                  I_RSP_VALID,
	input  wire logic [OUT_W-1:0]      I_RSP_ID,
	output logic                       O_RSP_FWD_VALID,
	output logic [IN_ID_W-1:0]         O_RSP_FWD_ID,
	output logic                       O_RSP_INT_VALID,
	output logic [1:0]                 O_RSP_INT_KIND
);
	localparam int WID = (OUT_W > IN_ID_W) ? OUT_W : IN_ID_W;

	logic                  id_valid_ff,  nxt_id_valid;
	logic [OUT_W-1:0]      id_ff,        nxt_id;
	logic                  ready_ff,     nxt_ready;
	logic                  fwd_valid_ff, nxt_fwd_valid;
	logic [IN_ID_W-1:0]    fwd_id_ff,    nxt_fwd_id;
	logic                  int_valid_ff, nxt_int_valid;
	logic [1:0]            int_kind_ff,  nxt_int_kind;
	logic                  cnt_full;
	logic                  take;
	logic                  retire;
	logic [OUT_W-1:0]      enc;
	logic [WID-1:0]        wide;

	assign take   = I_REQ_VALID && ready_ff;
	assign retire = I_RSP_VALID;

	// in-flight limit; ready drops at MAX_OUT outstanding, and also while an ID waits in its register
	aoid_out_cnt #(.MAX(MAX_OUT)) u_cnt (
		.i_clk    (I_CLK_SYS),
		.i_rst_n  (I_RST_N),
		.i_issue  (take),
		.i_retire (retire),
		.o_full   (cnt_full),
		.o_count  ()
	);

	always_comb begin
		wide = '0;
		unique case (I_REQ_SRC)
			aoid_pkg::AOID_SRC_FWD: begin
				wide[IN_ID_W-1:0] = I_REQ_ID;
			end
			aoid_pkg::AOID_SRC_BARRIER: begin
				wide = '1;
			end
			aoid_pkg::AOID_SRC_WALK: begin
				wide[OUT_W-1 -: 2] = aoid_pkg::AOID_WALK_TOP;
				wide[TAG_W-1:0]    = I_WALK_TAG;
			end
			aoid_pkg::AOID_SRC_SYNC_DONE: begin
				// narrow control port keeps only the top bits that fit
				if (OUT_W >= 3) begin
					wide[OUT_W-1 -: 3] = aoid_pkg::AOID_SYNC_TOP;
				end else begin
					wide[OUT_W-1 -: 2] = 2'h3;
				end
			end
		endcase
		enc = wide[OUT_W-1:0];
	end

	always_comb begin
		nxt_id_valid = id_valid_ff;
		nxt_id       = id_ff;
		if (id_valid_ff && I_ID_READY) begin
			nxt_id_valid = 1'b0;
		end
		if (take) begin
			nxt_id_valid = 1'b1;
			nxt_id       = enc;
		end
		// registered ready cannot see next downstream ready; wait for an empty slot
		nxt_ready = !cnt_full && !nxt_id_valid;
	end

	// response steering from the top ID bits
	always_comb begin
		nxt_fwd_valid = 1'b0;
		nxt_fwd_id    = fwd_id_ff;
		nxt_int_valid = 1'b0;
		nxt_int_kind  = int_kind_ff;
		if (I_RSP_VALID) begin
			if (!I_RSP_ID[OUT_W-1]) begin
				nxt_fwd_valid = 1'b1;
				nxt_fwd_id    = I_RSP_ID[IN_ID_W-1:0];
			end else begin
				nxt_int_valid = 1'b1;
				nxt_int_kind  = (OUT_W >= 2) ? I_RSP_ID[OUT_W-1 -: 2] : 2'h3;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			id_valid_ff  <= 1'b0;
			id_ff        <= '0;
			ready_ff     <= 1'b0;
			fwd_valid_ff <= 1'b0;
			fwd_id_ff    <= '0;
			int_valid_ff <= 1'b0;
			int_kind_ff  <= 2'h0;
		end else begin
			id_valid_ff  <= nxt_id_valid;
			id_ff        <= nxt_id;
			ready_ff     <= nxt_ready;
			fwd_valid_ff <= nxt_fwd_valid;
			fwd_id_ff    <= nxt_fwd_id;
			int_valid_ff <= nxt_int_valid;
			int_kind_ff  <= nxt_int_kind;
		end
	end

	assign O_REQ_READY     = ready_ff;
	assign O_ID_VALID      = id_valid_ff;
	assign O_ID            = id_ff;
	assign O_RSP_FWD_VALID = fwd_valid_ff;
	assign O_RSP_FWD_ID    = fwd_id_ff;
	assign O_RSP_INT_VALID = int_valid_ff;
	assign O_RSP_INT_KIND  = int_kind_ff;
endmodule : aoid_encoder

// [aoid_chk_sva.sv]
// Purpose: port checks for the output ID encoder
// Assumes: shared port whose top pair sits right above the walk tag
// Notes: responses steer one cycle after their pulse
`timescale 1ns/1ps
module aoid_chk #(
	parameter int IN_ID_W = 2,
	parameter int TAG_W   = 3,
	parameter int OUT_W   = 5
) (
	input wire logic                I_CLK_SYS,
	input wire logic                I_RST_N,
	input wire logic                I_REQ_VALID,
	input wire aoid_pkg::aoid_src_t I_REQ_SRC,
	input wire logic [IN_ID_W-1:0]  I_REQ_ID,
	input wire logic [TAG_W-1:0]    I_WALK_TAG,
	input wire logic                O_REQ_READY,
	input wire logic                O_ID_VALID,
	input wire logic [OUT_W-1:0]    O_ID,
	input wire logic                I_ID_READY,
	input wire logic                I_RSP_VALID,
	input wire logic [OUT_W-1:0]    I_RSP_ID,
	input wire logic                O_RSP_FWD_VALID,
	input wire logic [IN_ID_W-1:0]  O_RSP_FWD_ID,
	input wire logic                O_RSP_INT_VALID,
	input wire logic [1:0]          O_RSP_INT_KIND
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);
	wire take = I_REQ_VALID && O_REQ_READY;
	AST_FWD_ID: assert property (
		take && I_REQ_SRC == aoid_pkg::AOID_SRC_FWD |=> O_ID_VALID && O_ID == OUT_W'($past(I_REQ_ID))
	) else $error("bad forwarded id");
	AST_BAR_ID: assert property (
		take && I_REQ_SRC == aoid_pkg::AOID_SRC_BARRIER |=> O_ID_VALID && O_ID == '1
	) else $error("bad barrier id");
	AST_WALK_ID: assert property (
		take && I_REQ_SRC == aoid_pkg::AOID_SRC_WALK
			|=> O_ID == ((OUT_W'(2'h2) << (OUT_W - 2)) | OUT_W'($past(I_WALK_TAG)))
	) else $error("bad walk id");
	AST_SYNC_ID: assert property (
		take && I_REQ_SRC == aoid_pkg::AOID_SRC_SYNC_DONE |=> O_ID == (OUT_W'(3'h6) << (OUT_W - 3))
	) else $error("bad sync done id");
	AST_ID_HOLD: assert property (
		O_ID_VALID && !I_ID_READY |=> O_ID_VALID && $stable(O_ID)
	) else $error("id dropped while stalled");
	AST_NO_OVERWRITE: assert property (
		O_ID_VALID && !I_ID_READY |-> !O_REQ_READY
	) else $error("request open while id stalled");
	AST_RSP_FWD: assert property (
		I_RSP_VALID && !I_RSP_ID[OUT_W-1] |=> O_RSP_FWD_VALID && O_RSP_FWD_ID == $past(I_RSP_ID[IN_ID_W-1:0])
	) else $error("forwarded response lost");
	AST_RSP_INT: assert property (
		I_RSP_VALID && I_RSP_ID[OUT_W-1] |=> O_RSP_INT_VALID && O_RSP_INT_KIND == $past(I_RSP_ID[OUT_W-1 -: 2])
	) else $error("internal response lost");
	AST_RSP_NONE: assert property (
		!I_RSP_VALID |=> !O_RSP_FWD_VALID && !O_RSP_INT_VALID
	) else $error("response without cause");
endmodule : aoid_chk
bind aoid_encoder aoid_chk #(.IN_ID_W(IN_ID_W), .TAG_W(TAG_W), .OUT_W(OUT_W)) u_chk (.*);

// [aoid_slave.sv]
// Purpose: downstream slave model that takes ids and answers later
// Assumes: answers in order, one pulse then a gap
// Notes: idle response id keeps changing so stale values never match
`timescale 1ns/1ps
module aoid_slave (
	input  wire logic       i_clk,
	input  wire logic       i_stall,
	input  wire logic       i_hold,
	input  wire logic       i_id_valid,
	input  wire logic [4:0] i_id,
	output logic            o_id_ready,
	output logic            o_rsp_valid,
	output logic [4:0]      o_rsp_id
);
	logic [4:0] q[$];
	initial begin
		o_rsp_valid = 1'b0;
		o_rsp_id = 5'h00;
	end
	assign o_id_ready = !i_stall;
	always @(posedge i_clk) begin
		if (i_id_valid && o_id_ready)
			q.push_back(i_id);
		if (!o_rsp_valid && !i_hold && q.size() > 0) begin
			o_rsp_valid <= 1'b1;
			o_rsp_id <= q.pop_front();
		end else begin
			o_rsp_valid <= 1'b0;
			o_rsp_id <= ~o_rsp_id;
		end
	end
endmodule : aoid_slave

// [aoid_encoder_test.sv]
// Purpose: self-checking bench for the encoder on a shared port
// Assumes: five walk queues round up to a three-bit tag, two-bit master id
// Notes: outstanding limit shrunk to four to keep the run short
`timescale 1ns/1ps
module aoid_encoder_test;
	logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, stall = 1'b0, hold = 1'b0;
	aoid_pkg::aoid_src_t src = aoid_pkg::AOID_SRC_FWD;
	logic [1:0] rid = 2'h0, fid, kind;
	logic [2:0] tag = 3'h0;
	logic       rdy, idv, irdy, rv, fv, iv;
	logic [4:0] oid, rsp;
	int         n_fail = 0, num_checks = 0, cyc = 0, n_fwd = 0, n_int = 0;
	aoid_encoder #(.IN_ID_W(2), .WALK_QUEUES(5), .MAX_OUT(4), .MUXED(1'b1)) u_dut (
		.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REQ_VALID(vld), .I_REQ_SRC(src),
		.I_REQ_ID(rid), .I_WALK_TAG(tag), .O_REQ_READY(rdy), .O_ID_VALID(idv),
		.O_ID(oid), .I_ID_READY(irdy), .I_RSP_VALID(rv), .I_RSP_ID(rsp), .O_RSP_FWD_VALID(fv),
		.O_RSP_FWD_ID(fid), .O_RSP_INT_VALID(iv), .O_RSP_INT_KIND(kind));
	aoid_slave u_slv (.i_clk(clk), .i_stall(stall), .i_hold(hold), .i_id_valid(idv),
		.i_id(oid), .o_id_ready(irdy), .o_rsp_valid(rv), .o_rsp_id(rsp));
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			results();
		end
	end
	// response pulses counted at the edge after they are launched
	always @(posedge clk) begin
		if (fv === 1'b1)
			n_fwd++;
		if (iv === 1'b1)
			n_int++;
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic req(input aoid_pkg::aoid_src_t s, input logic [2:0] v, input logic [4:0] exp);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		src = s;
		rid = v[1:0];
		tag = v;
		vld = 1'b1;
		while (rdy !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("ready", 8'(rdy), 8'h01);
		@(posedge clk);
		#1;
		vld = 1'b0;
		check("id valid", 8'(idv), 8'h01);
		check("id", 8'(oid), 8'(exp));
	endtask : req
	task automatic test_ids;
		logic [4:0] e[4] = '{5'h01, 5'h1f, 5'h15, 5'h18};
		check("width", 8'($bits(u_dut.O_ID)), 8'h05);
		for (int i = 0; i < 4; i++)
			req(aoid_pkg::aoid_src_t'(i), 3'h5, e[i]);
		$display("test ids done");
	endtask : test_ids
	task automatic test_stall;
		@(posedge clk);
		#1;
		stall = 1'b1;
		req(aoid_pkg::AOID_SRC_BARRIER, 3'h0, 5'h1f);
		repeat (3) @(posedge clk);
		#1;
		check("held id", 8'(oid), 8'h1f);
		stall = 1'b0;
		$display("test stall done");
	endtask : test_stall
	task automatic test_full;
		repeat (4) @(posedge clk);
		#1;
		hold = 1'b1;
		for (int i = 0; i < 4; i++)
			req(aoid_pkg::AOID_SRC_FWD, 3'(i), 5'(i));
		repeat (2) @(posedge clk);
		#1;
		check("ready full", 8'(rdy), 8'h00);
		hold = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		check("ready drained", 8'(rdy), 8'h01);
		check("fwd responses", 8'(n_fwd), 8'h05);
		check("int responses", 8'(n_int), 8'h04);
		check("fwd rsp id", 8'(fid), 8'h03);
		check("int rsp kind", 8'(kind), 8'h03);
		$display("test full done");
	endtask : test_full
	task automatic results;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	initial begin
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		test_ids();
		test_stall();
		test_full();
		results();
	end
endmodule : aoid_encoder_test
